// ===== pmrc_regs.vh
/*
  constants for the power mode and reset controller: state codes and
  stabilisation counts. assumes a 100 MHz system clock.
*/
`ifndef PMRC_REGS_VH
`define PMRC_REGS_VH

`define PMRC_ST_RUN        2'h0
`define PMRC_ST_WAIT       2'h1
`define PMRC_ST_HALT       2'h2
`define PMRC_ST_STAB       2'h3

`define PMRC_STAB_INT_CYC  32'h0000_1000
`define PMRC_STAB_RST_CYC  32'h000F_4240
`define PMRC_CNT_W         20

`endif

// ===== pmrc_ctrl.v
/*
  power mode and reset controller: merges the reset pin and the watchdog
  reset, sequences wait and halt and the stabilisation delay on wake-up.
  assumes the cpu pulses wait_exec / halt_exec for one cycle per executed
  instruction, and that the interrupt controller supplies request levels.
*/
// Operation
// RQ1 - Reset comes only from the reset pin or the watchdog timeout.
// RQ2 - Any reset restarts the program from its first location.
// RQ3 - The reset pin is input only and internal resets never drive it.
// RQ4 - A reset from the pin acts at once, with no clock or filter.
// RQ5 - The outside party keeps the reset pin high in normal operation; low resets.
// RQ6 - Wait and halt are entered only by the wait and halt instructions.
// RQ7 - In wait the cpu stops while peripherals and watchdog keep running.
// RQ8 - Wait ends on any enabled interrupt or on reset.
// RQ9 - In wait the cpu clock keeps running; only execution is suspended.
// RQ10 - Halt switches off the oscillator and stops all peripherals.
// RQ11 - Halt with the watchdog enabled is a no-operation.
// RQ12 - Only the external interrupt or reset releases halt.
// RQ13 - Wake-up from halt waits 4096 cycles after interrupt, 1000000 after reset.
// RQ14 - After an interrupt wake-up the cpu serves the external interrupt routine.
// RQ15 - A masked external interrupt still wakes halt and takes the lowest routine.
// RQ16 - A mask bit at zero blocks its interrupt but keeps it pending.
// RQ17 - A counter started with the oscillator releases the cpu at its terminal count.
`timescale 1ns/1ps
`include "pmrc_regs.vh"

module pmrc_ctrl
#(
  parameter STAB_INT_CYC = `PMRC_STAB_INT_CYC,
  parameter STAB_RST_CYC = `PMRC_STAB_RST_CYC,
  parameter NIRQ         = 5
)
(
  // clock and reset
  input  wire            mclk,
  input  wire            sys_rst,
  // reset sources
  input  wire            rst_pin_n,
  input  wire            wdg_timeout,
  input  wire            wdg_enabled,
  // cpu instruction events
  input  wire            wait_exec,
  input  wire            halt_exec,
  // interrupt sources
  input  wire            ext_irq,
  input  wire            ext_irq_mask,
  input  wire [NIRQ-1:0] periph_irq,
  input  wire [NIRQ-1:0] periph_mask,
  // control outputs
  output wire            core_rst,
  output reg             pc_to_start,
  output reg             cpu_run,
  output reg             osc_enable,
  output reg             periph_clk_en,
  output reg             wake_ext_vec,
  output reg             wake_low_vec,
  output reg             wake_irq,
  output reg  [1:0]      pm_state
);

  localparam [1:0] ST_RUN  = `PMRC_ST_RUN;
  localparam [1:0] ST_WAIT = `PMRC_ST_WAIT;
  localparam [1:0] ST_HALT = `PMRC_ST_HALT;
  localparam [1:0] ST_STAB = `PMRC_ST_STAB;
  localparam [`PMRC_CNT_W-1:0] INT_TERM = STAB_INT_CYC[`PMRC_CNT_W-1:0] - 1'b1;
  localparam [`PMRC_CNT_W-1:0] RST_TERM = STAB_RST_CYC[`PMRC_CNT_W-1:0] - 1'b1;

  // pin reset acts asynchronously on every register except halt_mark; rst_pin_n is only read here
  wire pin_rst = ~rst_pin_n;                  // RQ4 RQ5 RQ3
  assign core_rst = sys_rst | pin_rst;        // RQ1

  // interrupt pin is asynchronous to mclk: two flops before any use
  reg        ext_irq_s1;
  reg        ext_irq_s2;

  // state and counters
  reg        halt_by_rst;
  reg        from_halt;
  reg        stab_ext;
  reg [`PMRC_CNT_W-1:0] stab_cnt;
  reg [`PMRC_CNT_W-1:0] stab_term;

  // halt memory lives across a pin reset so that a reset taken while
  // halted gets the long delay; a system reset or a cycle with cpu_run high and no halt_go clears it
  reg        halt_mark;

  // next values
  reg [1:0]  next_state;
  reg [`PMRC_CNT_W-1:0] next_cnt;
  reg [`PMRC_CNT_W-1:0] next_term;
  reg        next_stab_ext;
  reg        next_from_halt;
  reg        next_by_rst;
  reg        next_cpu_run;
  reg        next_osc;
  reg        next_periph;
  reg        next_pc;
  reg        next_wake_ext;
  reg        next_wake_low;
  reg        next_wake_irq;

  wire       any_enabled = |(periph_irq & periph_mask) | (ext_irq_s2 & ext_irq_mask); // RQ16
  wire       first_cycle = (pm_state == ST_STAB) && !from_halt && !halt_by_rst;
  wire       halt_go     = (pm_state == ST_RUN) && !wdg_timeout && halt_exec && !wdg_enabled;

  always @(posedge mclk or posedge core_rst)
  begin
    if (core_rst)
    begin
      ext_irq_s1 <= 1'b0;
      ext_irq_s2 <= 1'b0;
    end
    else
    begin
      ext_irq_s1 <= ext_irq;
      ext_irq_s2 <= ext_irq_s1;
    end
  end

  // set wins over the clear when halt follows a run cycle
  always @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
      halt_mark <= 1'b0;
    else if (halt_go)
      halt_mark <= 1'b1;                      // RQ13
    else if (cpu_run)
      halt_mark <= 1'b0;
  end

  always @*
  begin
    next_state     = pm_state;
    next_cnt       = stab_cnt;
    next_term      = stab_term;
    next_stab_ext  = stab_ext;
    next_from_halt = from_halt;
    next_by_rst    = halt_by_rst;
    next_cpu_run   = cpu_run;
    next_osc       = osc_enable;
    next_periph    = periph_clk_en;
    next_pc        = 1'b0;
    next_wake_ext  = 1'b0;
    next_wake_low  = 1'b0;
    next_wake_irq  = 1'b0;
    if (first_cycle)
    begin
      // first cycle after a pin or system reset picks the delay
      next_term      = halt_mark ? RST_TERM : INT_TERM; // RQ13
      next_from_halt = 1'b1;
      next_by_rst    = 1'b1;
      next_cnt       = {`PMRC_CNT_W{1'b0}};
      next_pc        = 1'b1;                  // RQ2
    end
    else if (wdg_timeout)
    begin
      // internal reset: restart program, pin left untouched
      next_state     = ST_RUN;                // RQ1 RQ3
      next_pc        = 1'b1;                  // RQ2
      next_cpu_run   = 1'b1;
      next_osc       = 1'b1;
      next_periph    = 1'b1;
      next_from_halt = 1'b0;
      next_by_rst    = 1'b0;
      next_stab_ext  = 1'b0;
      next_term      = INT_TERM;
    end
    else
    begin
      case (pm_state)
        ST_RUN:
        begin
          if (halt_go)                        // RQ6 RQ11
          begin
            next_state   = ST_HALT;
            next_cpu_run = 1'b0;
            next_osc     = 1'b0;              // RQ10
            next_periph  = 1'b0;              // RQ10
          end
          else if (wait_exec)                 // RQ6
          begin
            next_state   = ST_WAIT;
            next_cpu_run = 1'b0;              // RQ7 RQ9
          end
        end
        ST_WAIT:
        begin
          if (any_enabled)                    // RQ8
          begin
            next_state    = ST_RUN;
            next_cpu_run  = 1'b1;
            next_wake_irq = 1'b1;
          end
        end
        ST_HALT:
        begin
          // other sources stay pending while halted
          if (ext_irq_s2)                     // RQ12
          begin
            next_state     = ST_STAB;
            next_osc       = 1'b1;            // RQ13
            next_cnt       = {`PMRC_CNT_W{1'b0}}; // RQ17
            next_term      = INT_TERM;
            next_stab_ext  = 1'b1;
            next_from_halt = 1'b1;
            next_by_rst    = 1'b0;
          end
        end
        default:
        begin
          if (stab_cnt == stab_term)          // RQ17 RQ13
          begin
            next_state     = ST_RUN;
            next_cpu_run   = 1'b1;
            next_periph    = 1'b1;
            next_from_halt = 1'b0;
            next_by_rst    = 1'b0;
            next_term      = INT_TERM;
            next_stab_ext  = 1'b0;
            if (stab_ext)
            begin
              next_wake_irq = 1'b1;
              next_wake_ext = ext_irq_mask;   // RQ14
              next_wake_low = ~ext_irq_mask;  // RQ15
            end
          end
          else
            next_cnt = stab_cnt + 1'b1;       // RQ17
        end
      endcase
    end
  end

  always @(posedge mclk or posedge core_rst)
  begin
    if (core_rst)
    begin
      pm_state <= ST_STAB;
    end
    else
    begin
      pm_state <= next_state;
    end
  end

  always @(posedge mclk or posedge core_rst)
  begin
    if (core_rst)
    begin
      stab_cnt  <= {`PMRC_CNT_W{1'b0}};
      stab_term <= INT_TERM;
    end
    else
    begin
      stab_cnt  <= next_cnt;
      stab_term <= next_term;
    end
  end

  always @(posedge mclk or posedge core_rst)
  begin
    if (core_rst)
    begin
      stab_ext    <= 1'b0;
      from_halt   <= 1'b0;
      halt_by_rst <= 1'b0;
    end
    else
    begin
      stab_ext    <= next_stab_ext;
      from_halt   <= next_from_halt;
      halt_by_rst <= next_by_rst;
    end
  end

  always @(posedge mclk or posedge core_rst)
  begin
    if (core_rst)
    begin
      cpu_run       <= 1'b0;
      osc_enable    <= 1'b1;
      periph_clk_en <= 1'b1;
      pc_to_start   <= 1'b1;                  // RQ2
    end
    else
    begin
      cpu_run       <= next_cpu_run;
      osc_enable    <= next_osc;
      periph_clk_en <= next_periph;
      pc_to_start   <= next_pc;
    end
  end

  always @(posedge mclk or posedge core_rst)
  begin
    if (core_rst)
    begin
      wake_ext_vec <= 1'b0;
      wake_low_vec <= 1'b0;
      wake_irq     <= 1'b0;
    end
    else
    begin
      wake_ext_vec <= next_wake_ext;
      wake_low_vec <= next_wake_low;
      wake_irq     <= next_wake_irq;
    end
  end

endmodule // pmrc_ctrl

// ===== pmrc_ctrl_properties.sv
/* checker for pmrc_ctrl: state, clock and wake-up timing at the ports.
   assumes it is bound onto pmrc_ctrl and shares its port names. */
`timescale 1ns/1ps
module pmrc_ctrl_properties #(parameter int SI = 4096)
(
  // watched ports
  input logic       mclk, sys_rst, rst_pin_n, wdg_timeout, wdg_enabled,
  input logic       wait_exec, halt_exec, ext_irq, ext_irq_mask,
  input logic       core_rst, pc_to_start, cpu_run, osc_enable, periph_clk_en,
  input logic       wake_ext_vec, wake_low_vec, wake_irq,
  input logic [1:0] pm_state
);
  localparam int LO = SI - 2;
  localparam int HI = SI + 2;
  wire run = pm_state == 2'h0;
  default clocking @(posedge mclk); endclocking
  default disable iff (core_rst);
  // pin reset is checked while it is active, so nothing disables it
  a_pin_reset: assert property (disable iff (1'b0) !rst_pin_n |-> core_rst && pc_to_start)
    else $error("pin reset not immediate");
  a_halt_entry: assert property (run && halt_exec && !wdg_enabled && !wdg_timeout
    |=> pm_state == 2'h2 && !osc_enable && !periph_clk_en)
    else $error("halt entry wrong");
  a_halt_nop: assert property (run && halt_exec && wdg_enabled && !wait_exec && !wdg_timeout
    |=> run && cpu_run)
    else $error("halt not skipped");
  a_wait_clocks: assert property (pm_state == 2'h1 |-> osc_enable && periph_clk_en && !cpu_run)
    else $error("wait clocks wrong");
  a_halt_hold: assert property (pm_state == 2'h2 && !ext_irq |=> pm_state == 2'h2)
    else $error("halt left early");
  a_halt_wake: assert property (pm_state == 2'h2 && ext_irq |-> ##[1:3] pm_state == 2'h3 && osc_enable)
    else $error("halt wake wrong");
  a_stab_hold: assert property ($fell(pm_state == 2'h2) |-> (!cpu_run && pm_state == 2'h3)[*8])
    else $error("cpu released early");
  a_stab_len: assert property ($fell(pm_state == 2'h2) |-> ##[LO:HI] run && cpu_run && wake_irq)
    else $error("stabilisation length wrong");
  a_wait_exit: assert property (pm_state == 2'h1 && ext_irq && ext_irq_mask |-> ##[1:3] run && wake_irq)
    else $error("wait not left");
  a_wdg_restart: assert property (wdg_timeout |-> ##[0:1] pc_to_start)
    else $error("no restart on watchdog");
  c_ext: cover property (wake_ext_vec);
  c_low: cover property (wake_low_vec);
  c_wait: cover property (pm_state == 2'h1 ##1 run);
endmodule // pmrc_ctrl_properties
bind pmrc_ctrl pmrc_ctrl_properties #(.SI(STAB_INT_CYC)) u_props (
  .mclk(mclk), .sys_rst(sys_rst), .rst_pin_n(rst_pin_n), .wdg_timeout(wdg_timeout),
  .wdg_enabled(wdg_enabled), .wait_exec(wait_exec), .halt_exec(halt_exec),
  .ext_irq(ext_irq), .ext_irq_mask(ext_irq_mask), .core_rst(core_rst),
  .pc_to_start(pc_to_start), .cpu_run(cpu_run), .osc_enable(osc_enable),
  .periph_clk_en(periph_clk_en), .wake_ext_vec(wake_ext_vec), .wake_low_vec(wake_low_vec),
  .wake_irq(wake_irq), .pm_state(pm_state));

// ===== pmrc_cpu_model.sv
/* model of the cpu core, the reset pin source and the interrupt pin.
   assumes calls come from the bench just after a rising edge. */
`timescale 1ns/1ps
module pmrc_cpu_model
(
  // clock
  input  logic mclk,
  // toward the controller
  output logic rst_pin_n,
  output logic wait_exec,
  output logic halt_exec,
  output logic ext_irq
);
  initial
  begin
    rst_pin_n = 1'b1;
    wait_exec = 1'b0;
    halt_exec = 1'b0;
    ext_irq   = 1'b0;
  end
  // one-cycle instruction strobe: 1 wait, 2 halt
  task automatic exec(input int k);
    @(posedge mclk);
    wait_exec <= (k == 1);
    halt_exec <= (k == 2);
    @(posedge mclk);
    wait_exec <= 1'b0;
    halt_exec <= 1'b0;
  endtask
  // pin 0 is the reset pin, 1 the interrupt pin
  task automatic line(input int p, input logic v);
    @(posedge mclk);
    if (p == 0)
      rst_pin_n <= v;
    else
      ext_irq <= v;
  endtask
endmodule // pmrc_cpu_model

// ===== pmrc_ctrl_tb.sv
/* self-checking bench for pmrc_ctrl with a short stabilisation count.
   assumes pmrc_cpu_model drives the cpu and pin side. */
`timescale 1ns/1ps
`define CHK(n, e, a) begin checked++; if ((a) !== (e)) begin bad_count++; \
  $display("MISMATCH %s expected %0h seen %0h", n, e, a); end end
module pmrc_ctrl_tb;
  localparam int SI = 16;
  localparam int SR = 64;
  logic       mclk = 0, sys_rst = 1, wdg_timeout = 0, wdg_enabled = 0, ext_irq_mask = 0;
  logic [4:0] periph_irq = 0, periph_mask = 0;
  logic       rst_pin_n, wait_exec, halt_exec, ext_irq, core_rst, pc_to_start, cpu_run;
  logic       osc_enable, periph_clk_en, wake_ext_vec, wake_low_vec, wake_irq;
  logic [1:0] pm_state;
  int         bad_count = 0, checked = 0, cyc = 0, n, exp_state;
  pmrc_cpu_model m (.mclk(mclk), .rst_pin_n(rst_pin_n), .wait_exec(wait_exec),
    .halt_exec(halt_exec), .ext_irq(ext_irq));
  pmrc_ctrl #(.STAB_INT_CYC(SI), .STAB_RST_CYC(SR), .NIRQ(5)) dut (
    .mclk(mclk), .sys_rst(sys_rst), .rst_pin_n(rst_pin_n), .wdg_timeout(wdg_timeout),
    .wdg_enabled(wdg_enabled), .wait_exec(wait_exec), .halt_exec(halt_exec),
    .ext_irq(ext_irq), .ext_irq_mask(ext_irq_mask), .periph_irq(periph_irq),
    .periph_mask(periph_mask), .core_rst(core_rst), .pc_to_start(pc_to_start),
    .cpu_run(cpu_run), .osc_enable(osc_enable), .periph_clk_en(periph_clk_en),
    .wake_ext_vec(wake_ext_vec), .wake_low_vec(wake_low_vec), .wake_irq(wake_irq),
    .pm_state(pm_state));
  initial
  begin
    forever #5 mclk = ~mclk;
  end
  // a hang ends the run as a failure
  always @(posedge mclk)
  begin
    cyc++;
    if (cyc == 2000)
    begin
      bad_count++;
      complete_run();
    end
  end
  task automatic seek(ref logic s, input int lim);
    n = 0;
    do begin @(posedge mclk); #1; n++; end while (s !== 1'b1 && n < lim);
  endtask
  task automatic complete_run();
    $display("checked %0d bad %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  initial
  begin
    void'($urandom(32));
    repeat (16) @(posedge mclk);
    sys_rst <= 1'b0;
    seek(cpu_run, SI + 8);
    exp_state = 0;
    `CHK("state", exp_state[1:0], pm_state)
    for (int k = 0; k < 2; k++)
    begin
      m.exec(1); #1;
      `CHK("wait", 2'h1, pm_state)
      `CHK("clocks", 2'h3, {osc_enable, periph_clk_en})
      @(posedge mclk);
      ext_irq_mask <= 1'b1;
      periph_mask <= 5'h1F;
      if (k) m.line(1, 1'b1); else periph_irq <= $urandom | 1;
      seek(cpu_run, 4);
      `CHK("wait exit", exp_state[1:0], pm_state)
      m.line(1, 1'b0);
      periph_irq <= 5'h00;
    end
    $display("test wait done");
    @(posedge mclk);
    wdg_enabled <= 1'b1;
    m.exec(2); #1;
    `CHK("halt skipped", exp_state[1:0], pm_state)
    wdg_enabled <= 1'b0;
    $display("test halt skip done");
    for (int k = 0; k < 2; k++)
    begin
      ext_irq_mask <= k[0];
      m.exec(2); #1;
      `CHK("halt", 2'h2, pm_state)
      `CHK("osc", 1'b0, osc_enable)
      @(posedge mclk);
      periph_irq <= $urandom;
      repeat (3) @(posedge mclk); #1;
      `CHK("halt hold", 2'h2, pm_state)
      m.line(1, 1'b1);
      periph_irq <= 5'h00;
      seek(cpu_run, SI + 8);
      `CHK("stab length", 1'b1, n >= SI && n <= SI + 4)
      `CHK("ext vector", k[0], wake_ext_vec)
      `CHK("low vector", !k[0], wake_low_vec)
      m.line(1, 1'b0);
    end
    $display("test halt done");
    @(posedge mclk);
    wdg_timeout <= 1'b1;
    @(posedge mclk);
    wdg_timeout <= 1'b0;
    #1;
    `CHK("watchdog restart", 1'b1, pc_to_start)
    m.line(0, 1'b0); #1;
    `CHK("pin reset", 2'h2, {core_rst, cpu_run})
    m.line(0, 1'b1);
    seek(cpu_run, SI + 8);
    `CHK("restart", exp_state[1:0], pm_state)
    $display("test reset done");
    m.exec(2); #1;
    `CHK("halt again", 2'h2, pm_state)
    m.line(0, 1'b0);
    m.line(0, 1'b1);
    seek(cpu_run, SR + 8);
    `CHK("reset delay", 1'b1, n >= SR && n <= SR + 2)
    `CHK("halt reset restart", exp_state[1:0], pm_state)
    $display("test halt reset done");
    complete_run();
  end
endmodule // pmrc_ctrl_tb
